// [pkg/swl_pkg.sv]
// package: timing constants and command codes for the single-wire link ends
package swl_pkg;
  localparam int unsigned CLK_MHZ = 50;
  // times in microseconds, figures as used by both ends
  localparam int unsigned RESET_LOW_TIME_US          = 690;
  localparam int unsigned FAST_RESET_LOW_MAX_US      = 80;
  localparam int unsigned FAST_RESET_LOW_TIME_US     = 70;
  localparam int unsigned RESET_HIGH_TIME_US         = 480;
  localparam int unsigned FAST_RESET_HIGH_TIME_US    = 48;
  localparam int unsigned PRESENCE_DELAY_US          = 30;
  localparam int unsigned FAST_PRESENCE_DELAY_US     = 3;
  localparam int unsigned PRESENCE_LOW_TIME_US       = 120;
  localparam int unsigned FAST_PRESENCE_LOW_TIME_US  = 12;
  localparam int unsigned PRESENCE_SAMPLE_TIME_US    = 70;
  localparam int unsigned FAST_PRESENCE_SAMPLE_US    = 9;
  localparam int unsigned ONE_BIT_LOW_TIME_US        = 6;
  localparam int unsigned FAST_ONE_BIT_LOW_TIME_US   = 1;
  localparam int unsigned ZERO_BIT_LOW_TIME_US       = 60;
  localparam int unsigned FAST_ZERO_BIT_LOW_TIME_US  = 7;
  localparam int unsigned READ_LOW_TIME_US           = 6;
  localparam int unsigned FAST_READ_LOW_TIME_US      = 1;
  localparam int unsigned READ_SAMPLE_TIME_US        = 13;
  localparam int unsigned FAST_READ_SAMPLE_TIME_US   = 2;
  localparam int unsigned BIT_PERIOD_US              = 70;
  localparam int unsigned FAST_BIT_PERIOD_US         = 10;
  localparam int unsigned WRITE_SAMPLE_US            = 30;
  localparam int unsigned FAST_WRITE_SAMPLE_US       = 3;
  localparam int unsigned READ_HOLD_US               = 30;
  localparam int unsigned FAST_READ_HOLD_US          = 4;
  localparam int unsigned RISING_HOLDOFF_TIME_US     = 1;
  localparam int unsigned RESET_DETECT_US            = 440;
  localparam int unsigned FAST_RESET_DETECT_US       = 48;
  localparam int unsigned FALL_FILTER_CYC            = 8;
  localparam int unsigned CW = 16;
  // cycle counts: least times round up, longest round down
  localparam logic [CW-1:0] RST_LONG_CYC   = CW'(RESET_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] RST_DET_CYC    = CW'(RESET_DETECT_US * CLK_MHZ);
  localparam logic [CW-1:0] RST_DET_F_CYC  = CW'(FAST_RESET_DETECT_US * CLK_MHZ);
  localparam logic [CW-1:0] RST_LOW_CYC    = CW'((RESET_LOW_TIME_US + 10) * CLK_MHZ);
  localparam logic [CW-1:0] RST_LOW_F_CYC  = CW'(FAST_RESET_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] RST_HIGH_CYC   = CW'(RESET_HIGH_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] RST_HIGH_F_CYC = CW'(FAST_RESET_HIGH_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] PD_DLY_CYC     = CW'(PRESENCE_DELAY_US * CLK_MHZ);
  localparam logic [CW-1:0] PD_DLY_F_CYC   = CW'(FAST_PRESENCE_DELAY_US * CLK_MHZ);
  localparam logic [CW-1:0] PD_LOW_CYC     = CW'(PRESENCE_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] PD_LOW_F_CYC   = CW'(FAST_PRESENCE_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] PD_SMP_CYC     = CW'(PRESENCE_SAMPLE_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] PD_SMP_F_CYC   = CW'(FAST_PRESENCE_SAMPLE_US * CLK_MHZ);
  localparam logic [CW-1:0] W1_LOW_CYC     = CW'(ONE_BIT_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] W1_LOW_F_CYC   = CW'(FAST_ONE_BIT_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] W0_LOW_CYC     = CW'(ZERO_BIT_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] W0_LOW_F_CYC   = CW'(FAST_ZERO_BIT_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] RL_CYC         = CW'(READ_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] RL_F_CYC       = CW'(FAST_READ_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] RS_CYC         = CW'(READ_SAMPLE_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] RS_F_CYC       = CW'(FAST_READ_SAMPLE_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] SLOT_CYC       = CW'(BIT_PERIOD_US * CLK_MHZ);
  localparam logic [CW-1:0] SLOT_F_CYC     = CW'(FAST_BIT_PERIOD_US * CLK_MHZ);
  localparam logic [CW-1:0] WS_CYC         = CW'(WRITE_SAMPLE_US * CLK_MHZ);
  localparam logic [CW-1:0] WS_F_CYC       = CW'(FAST_WRITE_SAMPLE_US * CLK_MHZ);
  localparam logic [CW-1:0] RH_CYC         = CW'(READ_HOLD_US * CLK_MHZ);
  localparam logic [CW-1:0] RH_F_CYC       = CW'(FAST_READ_HOLD_US * CLK_MHZ);
  localparam logic [CW-1:0] REH_CYC        = CW'(RISING_HOLDOFF_TIME_US * CLK_MHZ);
  localparam logic [3:0]    FILT_CYC       = 4'(FALL_FILTER_CYC);
  // host command codes
  typedef enum logic [1:0] {SWL_CMD_RESET, SWL_CMD_WRITE, SWL_CMD_READ} swl_cmd_t;
endpackage : swl_pkg

// [pkg/swl_if.sv]
// interface: the open-drain data line between host and device
`timescale 1ns/1ps
`default_nettype none
interface swl_if;
  logic host_oe;   // host pulls low
  logic dev_oe;    // device pulls low
  logic line;      // wired-AND level, pulled up when nobody drives
  assign line = ~(host_oe | dev_oe);
  modport host (output host_oe, input line);
  modport dev  (output dev_oe, input line);
endinterface : swl_if
`default_nettype wire

// [hdl/swl_buf2.sv]
// two-entry valid/ready buffer for received bits
`timescale 1ns/1ps
`default_nettype none
module swl_buf2 (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic in_valid,
  output logic      in_ready,
  input  wire logic in_data,
  output logic      out_valid,
  input  wire logic out_ready,
  output logic      out_data
);
  logic [1:0] mem;
  logic [1:0] cnt;
  logic       rd_ptr;
  logic       wr_ptr;
  wire        push = in_valid & in_ready;
  wire        pop  = out_valid & out_ready;
  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rd_ptr];
  // pointers and occupancy; full and empty come from the count
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cnt    <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      mem    <= 2'h0;
    end
    else
    begin
      if (push) mem[wr_ptr] <= in_data;
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : swl_buf2
`default_nettype wire

// [hdl/swl_dev.sv]
// device end: slot timing, presence, speed mode and input filtering
// Functional notes
// [RULE1] four signal types, master starts all but presence
// [RULE2] standard speed unless overdrive; overdrive times everything
// [RULE3] reset low 690us or longer leaves overdrive
// [RULE4] overdrive survives resets of at most 80us
// [RULE5] slewing master lengthens reset by fall time
// [RULE6] after reset rise: wait, then presence low
// [RULE7] master samples presence at its sample instant
// [RULE8] reset high covers presence plus recovery
// [RULE9] mixed bus: longer reset high interval
// [RULE10] one bit per time slot, both directions
// [RULE11] falling edge starts the slot timer
// [RULE12] one bit: master releases before max low
// [RULE13] zero bit: master holds low past minimum
// [RULE14] recovery needed before the next slot
// [RULE15] read zero pulls low, read one releases
// [RULE16] master samples late, waits full slot
// [RULE17] standard speed filters falling edge, overdrive not
// [RULE18] glitches inside rising hold-off ignored
// [RULE19] overdrive commands set fast mode until long reset
// [RULE20] counters time durations, per-speed thresholds
`timescale 1ns/1ps
`default_nettype none
module swl_dev
  import swl_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  swl_if.dev        bus,
  input  wire logic go_fast,
  input  wire logic tx_bit,
  input  wire logic tx_valid,
  output logic      tx_taken,
  output logic      rx_valid,
  input  wire logic rx_ready,
  output logic      rx_bit,
  output logic      reset_seen,
  output logic      fast_speed_flag
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_PDLY, ST_PLOW, ST_HOLDOFF} swl_dev_state_t;
  swl_dev_state_t state;
  logic [CW-1:0] cnt;
  logic [1:0]    sync;
  logic [3:0]    filt;
  logic          line_q;
  logic          drive;
  logic          rd_slot;
  logic          rd_val;
  logic          sampled;
  logic          buf_valid;
  logic          buf_data;
  logic          buf_ready;
  logic          o_valid;
  logic          o_data;
  // per-speed thresholds picked by the mode flag  [RULE2] [RULE20]
  wire [CW-1:0] ws_cyc   = fast_speed_flag ? WS_F_CYC : WS_CYC;
  wire [CW-1:0] rh_cyc   = fast_speed_flag ? RH_F_CYC : RH_CYC;
  wire [CW-1:0] rst_det  = fast_speed_flag ? RST_DET_F_CYC : RST_DET_CYC;
  wire [CW-1:0] pd_dly   = fast_speed_flag ? PD_DLY_F_CYC : PD_DLY_CYC;
  wire [CW-1:0] pd_low   = fast_speed_flag ? PD_LOW_F_CYC : PD_LOW_CYC;
  // falling edge must stand FILT_CYC cycles at standard speed, one at fast  [RULE17]
  wire          low_seen = fast_speed_flag ? ~line_q : (filt == FILT_CYC);
  wire          cnt_max  = (cnt == {CW{1'b1}});
  wire          sample_now = (state == ST_LOW) && (cnt == ws_cyc) && !sampled && !rd_slot;
  // a write slot ends once its bit is taken and the line is up, a read slot once its hold is over
  wire          slot_end = line_q && !drive && (rd_slot ? (cnt >= rh_cyc) : sampled);
  // output register refills only when empty or being taken, so a stall keeps its bit
  wire          out_free = ~rx_valid | rx_ready;

  // two-flop synchroniser on the line pin; only the second stage is read
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      sync   <= 2'h3;
      line_q <= 1'b1;
    end
    else
    begin
      sync   <= {sync[0], bus.line};
      line_q <= sync[1];
    end
  end

  // low-pass on the start edge: count consecutive low samples
  always_ff @(posedge clock)
  begin
    if (!resetn) filt <= 4'h0;
    else if (line_q) filt <= 4'h0;
    else if (filt != FILT_CYC) filt <= filt + 4'h1;
  end

  // received bits go through a small buffer so a stalled consumer loses nothing until both entries are full
  swl_buf2 u_buf (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   (buf_data),
    .out_valid (o_valid),
    .out_ready (out_free),
    .out_data  (o_data)
  );

  // slot engine; the line low is the only thing that starts any activity  [RULE1] [RULE10]
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state           <= ST_IDLE;
      cnt             <= '0;
      drive           <= 1'b0;
      rd_slot         <= 1'b0;
      rd_val          <= 1'b1;
      sampled         <= 1'b0;
      buf_valid       <= 1'b0;
      buf_data        <= 1'b0;
      tx_taken        <= 1'b0;
      reset_seen      <= 1'b0;
      fast_speed_flag <= 1'b0;
    end
    else
    begin
      buf_valid  <= 1'b0;
      tx_taken   <= 1'b0;
      reset_seen <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (low_seen)
          begin
            // slot timer starts at the falling edge  [RULE11]
            state   <= ST_LOW;
            cnt     <= '0;
            sampled <= 1'b0;
            rd_slot <= tx_valid;
            rd_val  <= tx_bit;
            tx_taken <= tx_valid;
            drive   <= tx_valid & ~tx_bit; // [RULE15]
          end
        end
        ST_LOW:
        begin
          if (!cnt_max) cnt <= cnt + 1'b1;
          // write bit sampled at a fixed point, handed over only at slot end so a reset adds no bit
          if (sample_now)
          begin
            sampled  <= 1'b1;
            buf_data <= line_q;
          end
          if (rd_slot && cnt == rh_cyc) drive <= 1'b0; // [RULE15]
          if (slot_end)
          begin
            cnt <= '0;
            if (cnt >= rst_det)
            begin
              // reset pulse: long one drops fast mode, short one keeps it  [RULE3] [RULE4]
              if (cnt >= RST_LONG_CYC) fast_speed_flag <= 1'b0;
              reset_seen <= 1'b1;
              state      <= ST_PDLY;
            end
            else
            begin
              // no room in the buffer means the bit is dropped
              buf_valid <= ~rd_slot & buf_ready;
              state     <= ST_HOLDOFF; // [RULE14]
            end
          end
        end
        ST_PDLY:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == pd_dly) // [RULE6]
          begin
            state <= ST_PLOW;
            drive <= 1'b1;
            cnt   <= '0;
          end
        end
        ST_PLOW:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == pd_low) // [RULE6]
          begin
            drive <= 1'b0;
            state <= ST_HOLDOFF; // [RULE8]
            cnt   <= '0;
          end
        end
        ST_HOLDOFF:
        begin
          // lows inside the hold-off are glitches; later lows start a slot  [RULE18]
          cnt <= cnt + 1'b1;
          if (cnt >= REH_CYC) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // entry into fast mode wins over a long reset ending in the same cycle
      if (go_fast) fast_speed_flag <= 1'b1; // [RULE19]
    end
  end

  assign bus.dev_oe = drive;

  // user outputs registered from the buffer head
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      rx_valid <= 1'b0;
      rx_bit   <= 1'b0;
    end
    else
    begin
      rx_valid <= o_valid | (rx_valid & ~rx_ready);
      if (o_valid && out_free) rx_bit <= o_data;
    end
  end
endmodule : swl_dev
`default_nettype wire

// [hdl/swl_host.sv]
// host end: generates reset, write and read slots on the line
`timescale 1ns/1ps
`default_nettype none
module swl_host
  import swl_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  resetn,
  swl_if.host        bus,
  input  wire logic  cmd_valid,
  input  wire swl_cmd_t cmd,
  input  wire logic  cmd_bit,
  input  wire logic  fast,
  output logic       cmd_ready,
  output logic       done,
  output logic       result
);
  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH} swl_host_state_t;
  swl_host_state_t state;
  swl_cmd_t        op;
  logic            val;
  logic            drive;
  logic [CW-1:0]   cnt;
  logic [1:0]      sync;
  // per-speed timing of the master side; standard-speed reset low carries fall-time margin  [RULE5]
  wire [CW-1:0] low_len = (op == SWL_CMD_RESET) ? (fast ? RST_LOW_F_CYC : RST_LOW_CYC) :
                          (op == SWL_CMD_READ)  ? (fast ? RL_F_CYC : RL_CYC) :
                          val ? (fast ? W1_LOW_F_CYC : W1_LOW_CYC) : (fast ? W0_LOW_F_CYC : W0_LOW_CYC);
  wire [CW-1:0] tot_len = (op == SWL_CMD_RESET) ? (fast ? RST_HIGH_F_CYC : RST_HIGH_CYC) :
                          (fast ? SLOT_F_CYC : SLOT_CYC);
  wire [CW-1:0] smp_at  = (op == SWL_CMD_RESET) ? (fast ? PD_SMP_F_CYC : PD_SMP_CYC) :
                          (fast ? RS_F_CYC : RS_CYC);

  always_ff @(posedge clock)
  begin
    if (!resetn) sync <= 2'h3;
    else sync <= {sync[0], bus.line};
  end

  // one slot at a time; reset high interval covers presence and recovery
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state     <= HS_IDLE;
      op        <= SWL_CMD_RESET;
      val       <= 1'b0;
      drive     <= 1'b0;
      cnt       <= '0;
      cmd_ready <= 1'b1;
      done      <= 1'b0;
      result    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        HS_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            op        <= cmd;
            val       <= cmd_bit;
            drive     <= 1'b1;
            cnt       <= '0;
            cmd_ready <= 1'b0;
            state     <= HS_LOW;
          end
        end
        HS_LOW:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == low_len)
          begin
            drive <= 1'b0;
            cnt   <= '0;
            state <= HS_HIGH;
          end
        end
        HS_HIGH:
        begin
          cnt <= cnt + 1'b1;
          // presence is low, a read one is high
          if (cnt == smp_at) result <= (op == SWL_CMD_RESET) ? ~sync[1] : sync[1]; // [RULE7]
          if (cnt == tot_len) // [RULE9] [RULE16]
          begin
            done      <= 1'b1;
            cmd_ready <= 1'b1;
            state     <= HS_IDLE;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  assign bus.host_oe = drive;
endmodule : swl_host
`default_nettype wire

// [test/swl_chk.sv]
// checker: wire-level timing relations between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module swl_chk
  import swl_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic host_oe,
  input  wire logic dev_oe,
  input  wire logic line
);
  logic [CW-1:0] host_cnt, dev_cnt, high_cnt, pend_cnt;
  logic [CW-1:0] next_host_cnt, next_dev_cnt, next_high_cnt, next_pend_cnt;
  logic          host_q, pend, next_pend, long_rel;

  // run lengths; idle count saturates so a cold start looks like a long idle line
  assign next_host_cnt = host_oe ? host_cnt + 16'h0001 : 16'h0000;
  assign next_dev_cnt  = dev_oe ? dev_cnt + 16'h0001 : 16'h0000;
  assign next_high_cnt = !line ? 16'h0000 : ((&high_cnt) ? high_cnt : high_cnt + 16'h0001);
  assign long_rel      = host_q && !host_oe && (host_cnt >= RST_LOW_F_CYC - 16'h0002);
  assign next_pend     = long_rel | (pend & ~dev_oe);  // presence owed after a reset
  assign next_pend_cnt = pend ? pend_cnt + 16'h0001 : 16'h0000;

  // helper registers
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      {host_cnt, dev_cnt, pend_cnt} <= 48'h000000000000;
      high_cnt <= 16'hFFFF;
      {host_q, pend} <= 2'h0;
    end
    else
    begin
      {host_cnt, dev_cnt, pend_cnt} <= {next_host_cnt, next_dev_cnt, next_pend_cnt};
      high_cnt <= next_high_cnt;
      {host_q, pend} <= {host_oe, next_pend};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence read_release;
    $fell(host_oe) && dev_oe;
  endsequence
  sequence dev_holds;
    dev_oe [*8];
  endsequence

  chk_read_pull_start: assert property ($rose(dev_oe) && host_oe |-> host_cnt <= 16'h0018)
    else $error("device pull started late in the slot");
  chk_no_self_start: assert property ($rose(dev_oe) |-> host_oe || pend)
    else $error("device pulled the idle line");
  chk_presence_delay: assert property ($rose(dev_oe) && !host_oe |->
      high_cnt >= PD_DLY_F_CYC && high_cnt <= PD_DLY_CYC + 16'h0014)
    else $error("presence delay out of range");
  chk_presence_owed: assert property (pend_cnt <= PD_DLY_CYC + 16'h0014)
    else $error("no presence after reset");
  chk_pull_length: assert property (dev_cnt <= PD_LOW_CYC + 16'h0008)
    else $error("device pull too long");
  chk_read_hold: assert property (read_release |-> dev_holds)
    else $error("read zero released with the host");
  chk_bit_low_len: assert property ($fell(host_oe) |->
      (host_cnt <= W1_LOW_CYC + 16'h0002) || (host_cnt >= W0_LOW_F_CYC - 16'h0002))
    else $error("host low time between one and zero limits");
  chk_slot_recovery: assert property ($rose(host_oe) |-> high_cnt >= 16'h0032)
    else $error("slot started without recovery");
endmodule // swl_chk
`default_nettype wire

// [test/swl_tb.sv]
// testbench: host and device ends joined on one line, driven through their user sides
`timescale 1ns/1ps
`default_nettype none
module swl_tb;
  import swl_pkg::*;
  logic     clock, resetn, cmd_valid, cmd_bit, fast, cmd_ready, done, result;
  logic     go_fast, tx_bit, tx_valid, tx_taken, rx_valid, rx_ready, rx_bit;
  logic     reset_seen, fast_speed_flag;
  swl_cmd_t cmd;
  int       failures, n_checks, n_taken, n_rst;
  logic     rxq[$];

  swl_if u_link ();
  swl_host u_swl_host (.clock(clock), .resetn(resetn), .bus(u_link.host), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_bit(cmd_bit), .fast(fast), .cmd_ready(cmd_ready), .done(done), .result(result));
  swl_dev u_swl_dev (.clock(clock), .resetn(resetn), .bus(u_link.dev), .go_fast(go_fast),
    .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_taken(tx_taken), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_bit(rx_bit), .reset_seen(reset_seen), .fast_speed_flag(fast_speed_flag));
  swl_chk u_swl_chk (.clock(clock), .resetn(resetn), .host_oe(u_link.host_oe),
    .dev_oe(u_link.dev_oe), .line(u_link.line));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // collect handed-over bits and pulses; reads pre-edge values
  always @(posedge clock)
  begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_bit);
    if (tx_taken === 1'b1) n_taken++;
    if (reset_seen === 1'b1) n_rst++;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one command: hold valid until ready, then wait for done (sampled at falling edges)
  task automatic run(input swl_cmd_t c, input logic b);
    int k;
    @(negedge clock);
    cmd = c;
    cmd_bit = b;
    cmd_valid = 1'b1;
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    for (k = 0; k < 70000 && done !== 1'b1; k++) @(negedge clock);
    check(16'(done), 16'h0001);
    check(16'(cmd_ready), 16'h0001);
  endtask

  task automatic wr(input logic b);
    run(SWL_CMD_WRITE, b);
    check(16'(rxq.size()), 16'h0001);
    if (rxq.size() > 0) check(16'(rxq.pop_front()), 16'(b));
  endtask

  task automatic rd(input logic b);
    int t0;
    t0 = n_taken;
    tx_bit = b;
    tx_valid = 1'b1;
    run(SWL_CMD_READ, 1'b0);
    tx_valid = 1'b0;
    check(16'(result), 16'(b));
    check(16'(n_taken - t0), 16'h0001);
  endtask

  task automatic rst(input logic fe);
    int r0;
    r0 = n_rst;
    run(SWL_CMD_RESET, 1'b0);
    check(16'(result), 16'h0001);
    check(16'(n_rst - r0), 16'h0001);
    check(16'(fast_speed_flag), 16'(fe));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs some 88200 cycles
  initial
  begin
    repeat (96000) @(posedge clock);
    failures++;
    $display("unexpected at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    final_report();
  end

  initial
  begin
    {resetn, cmd_valid, cmd_bit, fast, go_fast, tx_bit, tx_valid} = 7'h00;
    cmd = SWL_CMD_RESET;
    rx_ready = 1'b1;
    {failures, n_checks, n_taken, n_rst} = {4{32'h00000000}};
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    check(16'(fast_speed_flag), 16'h0000);
    // fast mode entry, short reset keeps it
    go_fast = 1'b1;
    @(negedge clock);
    go_fast = 1'b0;
    fast = 1'b1;
    @(negedge clock);
    check(16'(fast_speed_flag), 16'h0001);
    rst(1'b1);
    wr(1'b1);
    wr(1'b0);
    rd(1'b0);
    rd(1'b1);
    $display("test fast slots finished");
    // receiver stalls: output register and both buffer entries keep a bit, the fourth is dropped
    rx_ready = 1'b0;
    run(SWL_CMD_WRITE, 1'b1);
    run(SWL_CMD_WRITE, 1'b0);
    run(SWL_CMD_WRITE, 1'b1);
    run(SWL_CMD_WRITE, 1'b0);
    check(16'(rx_valid), 16'h0001);
    check(16'(rxq.size()), 16'h0000);
    rx_ready = 1'b1;
    repeat (6) @(negedge clock);
    check(16'(rxq.size()), 16'h0003);
    while (rxq.size() < 3) rxq.push_back(1'bx);
    check(16'(rxq.pop_front()), 16'h0001);
    check(16'(rxq.pop_front()), 16'h0000);
    check(16'(rxq.pop_front()), 16'h0001);
    check(16'(rx_valid), 16'h0000);
    rxq.delete();
    $display("test stalled buffer finished");
    // long reset returns to standard speed, slots then filtered and slower
    fast = 1'b0;
    rst(1'b0);
    wr(1'b0);
    wr(1'b1);
    rd(1'b1);
    rd(1'b0);
    $display("test standard slots finished");
    final_report();
  end
endmodule // swl_tb
`default_nettype wire
